//--- logic/parallel_command_decoder.sv
/*
 Parallel command decoder: trigger and command word pins to one-cycle action pulses,
 bank and group selections, and result/error output clears.
 Assumes pins are asynchronous, the far end keeps the settling time, and run_mode
 comes from logic on mclk.
*/
`timescale 1ns/1ps
module parallel_command_decoder
	import cmd_decode_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                run_mode,
	input  wire logic                measure_trigger,
	input  wire logic [WORD_W-1:0]   command_word_lines,
	input  wire logic                command_confirm_strobe,
	input  wire logic                measure_busy,
	input  wire logic                error_event,
	input  wire logic                overall_result_in,
	input  wire logic [RESULT_W-1:0] result_data_in,
	input  wire logic                result_load,
	output cmd_pulse_t               action,
	output logic [PARAM_W-1:0]       active_bank,
	output logic [PARAM_W-1:0]       active_group,
	output logic [PARAM_W-1:0]       rereg_item,
	output logic                     error_out,
	output logic                     overall_result_out,
	output logic [RESULT_W-1:0]      result_data_out
);
	logic [WORD_W+1:0] pins_s;
	logic              measure_trigger_s;
	logic              conf_s;
	cmd_word_t         word_s;

	// ==========================================
	// Pin synchronisation
	pin_sync #(
		.W(WORD_W + 2)
	) u_sync (
		.mclk         (mclk),
		.rst_b        (rst_b),
		.pin          ({measure_trigger, command_confirm_strobe, command_word_lines}),
		.pin_sync_out (pins_s)
	);

	assign measure_trigger_s = pins_s[WORD_W+1];
	assign conf_s = pins_s[WORD_W];
	assign word_s = cmd_word_t'(pins_s[WORD_W-1:0]);

	// ==========================================
	// Edge tracking
	logic              measure_trigger_d_r;
	logic              measure_trigger_d_nxt;
	edge_state_t       conf_st_r;
	edge_state_t       conf_st_nxt;
	logic              conf_rise;
	logic              measure_trigger_rise;

	// Edges are seen regardless of mode so a strobe held across entry to run does not fire
	always_comb begin
		measure_trigger_d_nxt  = measure_trigger_s;
		conf_rise   = 1'b0;
		conf_st_nxt = conf_st_r;
		case (conf_st_r)
			EDGE_IDLE: begin
				if (conf_s) begin
					conf_rise   = 1'b1;
					conf_st_nxt = EDGE_HIGH;
				end
			end
			EDGE_HIGH: begin
				conf_st_nxt = conf_s ? EDGE_HOLD : EDGE_IDLE;
			end
			EDGE_HOLD: begin
				if (!conf_s) begin
					conf_st_nxt = EDGE_IDLE;
				end
			end
			default: begin
				conf_st_nxt = EDGE_IDLE;
			end
		endcase
	end

	assign measure_trigger_rise = measure_trigger_s & ~measure_trigger_d_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			measure_trigger_d_r  <= 1'b0;
			conf_st_r <= EDGE_IDLE;
		end else begin
			measure_trigger_d_r  <= measure_trigger_d_nxt;
			conf_st_r <= conf_st_nxt;
		end
	end

	// ==========================================
	// Command state
	logic              cont_r;
	logic              cont_nxt;
	logic [PARAM_W-1:0] bank_r;
	logic [PARAM_W-1:0] bank_nxt;
	logic [PARAM_W-1:0] group_r;
	logic [PARAM_W-1:0] group_nxt;
	logic [PARAM_W-1:0] item_r;
	logic [PARAM_W-1:0] item_nxt;
	cmd_pulse_t        act_r;
	cmd_pulse_t        act_nxt;
	logic              err_r;
	logic              err_nxt;
	logic              or_r;
	logic              or_nxt;
	logic [RESULT_W-1:0] do_r;
	logic [RESULT_W-1:0] do_nxt;
	logic              take;
	logic              clr_outputs;

	assign take = conf_rise & run_mode;

	always_comb begin
		cont_nxt  = cont_r;
		bank_nxt  = bank_r;
		group_nxt = group_r;
		item_nxt  = item_r;
		act_nxt   = '0;
		if (take) begin
			case (word_s.code)
				CODE_CONT: begin
					cont_nxt = 1'b1;
				end
				CODE_BANK: begin
					bank_nxt         = word_s.param;
					act_nxt.bank_set = 1'b1;
				end
				CODE_GROUP: begin
					group_nxt         = word_s.param;
					act_nxt.group_set = 1'b1;
				end
				CODE_REREG: begin
					// Five lines cap the reachable item at 31
					item_nxt      = word_s.param;
					act_nxt.rereg = 1'b1;
				end
				CODE_CLEAR: begin
					act_nxt.clr_data = (word_s.param == PAR_CLR_DATA);
					act_nxt.clr_err  = (word_s.param == PAR_CLR_ERR);
					act_nxt.clr_out  = (word_s.param == PAR_CLR_OUT);
				end
				default: begin
					act_nxt = '0;
				end
			endcase
		end
		// Continuous run ends with the confirm line or leaving run mode
		if (!conf_s || !run_mode) begin
			cont_nxt = 1'b0;
		end
		// Re-issue while idle; the measurement engine paces repeats through busy
		act_nxt.measure = run_mode & (measure_trigger_rise | (cont_r & ~measure_busy));
	end

	// ==========================================
	// Output pins
	assign clr_outputs = act_r.clr_data | act_r.clr_out;

	always_comb begin
		err_nxt = err_r;
		or_nxt  = or_r;
		do_nxt  = do_r;
		if (act_r.clr_err) begin
			err_nxt = 1'b0;
		end
		// A new error in the clearing cycle wins
		if (error_event) begin
			err_nxt = 1'b1;
		end
		if (clr_outputs) begin
			or_nxt = 1'b0;
			do_nxt = '0;
		end
		if (result_load) begin
			or_nxt = overall_result_in;
			do_nxt = result_data_in;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cont_r  <= 1'b0;
			bank_r  <= BANK_RST;
			group_r <= GROUP_RST;
			item_r  <= '0;
			act_r   <= '0;
			err_r   <= 1'b0;
			or_r    <= 1'b0;
			do_r    <= '0;
		end else begin
			cont_r  <= cont_nxt;
			bank_r  <= bank_nxt;
			group_r <= group_nxt;
			item_r  <= item_nxt;
			act_r   <= act_nxt;
			err_r   <= err_nxt;
			or_r    <= or_nxt;
			do_r    <= do_nxt;
		end
	end

	assign action             = act_r;
	assign active_bank        = bank_r;
	assign active_group       = group_r;
	assign rereg_item         = item_r;
	assign error_out          = err_r;
	assign overall_result_out = or_r;
	assign result_data_out    = do_r;
endmodule

//--- logic/cmd_decode_pkg.sv
/*
 Shared constants and carrier types for the parallel command decoder.
 Assumes a single 40 MHz clock and that all pins are synchronised inside the decoder.
*/
package cmd_decode_pkg;
	// ==========================================
	// Word layout
	localparam int unsigned WORD_W     = 8;
	localparam int unsigned CODE_MSB   = 7;
	localparam int unsigned CODE_LSB   = 5;
	localparam int unsigned PARAM_W    = 5;
	localparam int unsigned RESULT_W   = 16;

	// ==========================================
	// Command codes
	localparam logic [2:0] CODE_CONT   = 3'h0;
	localparam logic [2:0] CODE_BANK   = 3'h2;
	localparam logic [2:0] CODE_GROUP  = 3'h6;
	localparam logic [2:0] CODE_REREG  = 3'h4;
	localparam logic [2:0] CODE_CLEAR  = 3'h5;
	localparam logic [4:0] PAR_CLR_DATA = 5'h00;
	localparam logic [4:0] PAR_CLR_ERR  = 5'h01;
	localparam logic [4:0] PAR_CLR_OUT  = 5'h02;

	// ==========================================
	// Reset values and timing
	localparam logic [4:0] BANK_RST    = 5'h00;
	localparam logic [4:0] GROUP_RST   = 5'h00;
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned SETTLE_MS  = 5;
	localparam int unsigned SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;

	typedef struct packed {
		logic [2:0] code;
		logic [4:0] param;
	} cmd_word_t;

	typedef struct packed {
		logic       measure;
		logic       bank_set;
		logic       group_set;
		logic       rereg;
		logic       clr_data;
		logic       clr_err;
		logic       clr_out;
	} cmd_pulse_t;

	typedef enum logic [2:0] {
		EDGE_IDLE = 3'b001,
		EDGE_HIGH = 3'b010,
		EDGE_HOLD = 3'b100
	} edge_state_t;
endpackage

//--- logic/pin_sync.sv
/*
 Two-flop synchroniser for a bus of asynchronous pins.
 Assumes the pins are quasi-static relative to mclk.
*/
`timescale 1ns/1ps
module pin_sync
	import cmd_decode_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] pin_sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// ==========================================
	// Stage logic
	always_comb begin
		meta_nxt = pin;
		sync_nxt = meta_r;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign pin_sync_out = sync_r;
endmodule

//--- tb/decoder_props.sv
/*
 Port checker for the parallel command decoder.
 Assumes the far end holds the word steady around each confirm.
*/
`timescale 1ns/1ps
module decoder_props
	import cmd_decode_pkg::*;
(
	input wire logic                mclk,
	input wire logic                rst_b,
	input wire logic                run_mode,
	input wire logic [WORD_W-1:0]   command_word_lines,
	input wire logic                error_event,
	input wire logic                result_load,
	input wire logic [RESULT_W-1:0] result_data_in,
	input wire cmd_pulse_t          action,
	input wire logic [PARAM_W-1:0]  active_bank,
	input wire logic [PARAM_W-1:0]  active_group,
	input wire logic [PARAM_W-1:0]  rereg_item,
	input wire logic                error_out,
	input wire logic                overall_result_out,
	input wire logic [RESULT_W-1:0] result_data_out
);
	// ==========
	// Properties
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_idle; (!run_mode)[*3] |=> action == '0; endproperty
	a_idle: assert property (p_idle) else $error("action outside run");
	property p_bank;
		action.bank_set |-> active_bank == $past(command_word_lines[4:0], 2)
			&& $past(command_word_lines[7:5], 2) == CODE_BANK;
	endproperty
	a_bank: assert property (p_bank) else $error("bank value");
	property p_group;
		action.group_set |-> active_group == $past(command_word_lines[4:0], 2)
			&& $past(command_word_lines[7:5], 2) == CODE_GROUP;
	endproperty
	a_group: assert property (p_group) else $error("group value");
	property p_rereg; action.rereg |-> rereg_item == $past(command_word_lines[4:0], 2); endproperty
	a_rereg: assert property (p_rereg) else $error("item value");
	property p_once; action.bank_set |=> !action.bank_set; endproperty
	a_once: assert property (p_once) else $error("pulse too long");
	property p_clr_err; action.clr_err && !error_event |=> !error_out; endproperty
	a_clr_err: assert property (p_clr_err) else $error("error not cleared");
	property p_err; error_event |=> error_out; endproperty
	a_err: assert property (p_err) else $error("error not set");
	property p_clr_out;
		(action.clr_out || action.clr_data) && !result_load |=>
			result_data_out == '0 && !overall_result_out;
	endproperty
	a_clr_out: assert property (p_clr_out) else $error("outputs not cleared");
	property p_load; result_load |=> result_data_out == $past(result_data_in); endproperty
	a_load: assert property (p_load) else $error("outputs not loaded");
	c_bank: cover property (action.bank_set);
	c_rereg: cover property (action.rereg);
	c_meas: cover property (action.measure);
endmodule

//--- tb/plc_model.sv
/*
 External controller driving the command pins.
 Assumes mclk timing; settle time shortened to 3 cycles.
*/
`timescale 1ns/1ps
module plc_model (
	input  wire logic mclk,
	output logic [7:0] command_word_lines,
	output logic       command_confirm_strobe
);
	initial begin
		command_word_lines     = 8'h00;
		command_confirm_strobe = 1'b0;
	end
	// ==========
	// Word first, confirm later; released lines show the inverse
	task automatic send(input logic [7:0] w);
		@(negedge mclk) command_word_lines = w;
		repeat (3) @(negedge mclk);
		command_confirm_strobe = 1'b1;
		repeat (8) @(negedge mclk);
		command_confirm_strobe = 1'b0;
		repeat (4) @(negedge mclk);
		command_word_lines = ~w;
	endtask
endmodule

//--- tb/parallel_command_decoder_bench.sv
/*
 Testbench for the parallel command decoder.
 Assumes plc_model drives the command pins.
*/
`timescale 1ns/1ps
module parallel_command_decoder_bench;
	import cmd_decode_pkg::*;
	logic mclk, rst_b, run_mode, measure_trigger, measure_busy, error_event;
	logic overall_result_in, result_load, error_out, overall_result_out, conf;
	logic [RESULT_W-1:0] result_data_in, result_data_out;
	logic [WORD_W-1:0]   word;
	logic [PARAM_W-1:0]  active_bank, active_group, rereg_item;
	cmd_pulse_t          action;
	int error_cnt, tests_run, mcnt, m;
	plc_model plc_inst (.mclk(mclk), .command_word_lines(word), .command_confirm_strobe(conf));
	parallel_command_decoder parallel_command_decoder_inst (.mclk(mclk), .rst_b(rst_b),
		.run_mode(run_mode), .measure_trigger(measure_trigger), .command_word_lines(word),
		.command_confirm_strobe(conf), .measure_busy(measure_busy), .error_event(error_event),
		.overall_result_in(overall_result_in), .result_data_in(result_data_in),
		.result_load(result_load), .action(action), .active_bank(active_bank),
		.active_group(active_group), .rereg_item(rereg_item), .error_out(error_out),
		.overall_result_out(overall_result_out), .result_data_out(result_data_out));
	always @(posedge mclk) if (action.measure === 1'b1) mcnt++;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n); repeat (n) @(negedge mclk); endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		rst_b = 0; run_mode = 1; measure_trigger = 0; measure_busy = 0; error_event = 0;
		overall_result_in = 0; result_load = 0; result_data_in = '0;
		error_cnt = 0;
		tests_run = 0;
		cyc(4);
		rst_b = 1;
		cyc(2);
		chk("bank_rst", 16'(BANK_RST), 16'(active_bank));
		m = mcnt; measure_trigger = 1; cyc(10); measure_trigger = 0; cyc(4);
		chk("trigger", 16'(m + 1), 16'(mcnt));
		plc_inst.send(8'h5F);
		chk("bank", 16'h1F, 16'(active_bank));
		plc_inst.send(8'hD5);
		chk("group", 16'h15, 16'(active_group));
		plc_inst.send(8'h9F);
		chk("item", 16'h1F, 16'(rereg_item));
		$display("test select done");
		// Run mode off: pins must be dropped, not replayed later
		run_mode = 0; m = mcnt;
		plc_inst.send(8'h43);
		measure_trigger = 1; cyc(6); measure_trigger = 0; cyc(4); run_mode = 1; cyc(4);
		chk("idle_bank", 16'h1F, 16'(active_bank));
		chk("idle_meas", 16'(m), 16'(mcnt));
		plc_inst.send(8'h23);
		chk("unlisted", 16'h1F, 16'(active_bank));
		error_event = 1; cyc(1); error_event = 0; cyc(1);
		plc_inst.send(8'hBF);
		chk("err_keep", 16'h1, 16'(error_out));
		plc_inst.send(8'hA1);
		chk("err_clr", 16'h0, 16'(error_out));
		$display("test refuse done");
		// First pass clears outputs only, second pass clears measured data
		for (int i = 0; i < 2; i++) begin
			result_data_in = 16'hA5C3;
			overall_result_in = 1;
			result_load = 1;
			cyc(1);
			result_load = 0;
			cyc(2);
			chk("load", 16'hA5C3, result_data_out);
			chk("load_or", 16'h1, 16'(overall_result_out));
			plc_inst.send(i == 0 ? 8'hA2 : 8'hA0);
			chk("clr", 16'h0, result_data_out);
			chk("clr_or", 16'h0, 16'(overall_result_out));
		end
		m = mcnt;
		plc_inst.send(8'h1F);
		// Confirm stands 8 cycles and both edges pass the same sync delay: 8 pulses
		chk("cont", 16'h8, 16'(mcnt - m));
		m = mcnt; cyc(10);
		chk("cont_stop", 16'(m), 16'(mcnt));
		// Busy engine holds off every repeat
		measure_busy = 1;
		m = mcnt;
		plc_inst.send(8'h00);
		measure_busy = 0;
		cyc(4);
		chk("cont_busy", 16'(m), 16'(mcnt));
		$display("test clear done");
		// Mid-run reset must bring the selections back to their reset values
		rst_b = 0;
		cyc(2);
		rst_b = 1;
		cyc(2);
		chk("bank_rst2", 16'(BANK_RST), 16'(active_bank));
		chk("group_rst2", 16'(GROUP_RST), 16'(active_group));
		$display("test reset done");
		results();
	end
	initial begin
		#1ms;
		error_cnt++;
		results();
	end
endmodule
bind parallel_command_decoder decoder_props decoder_props_inst (.mclk(mclk), .rst_b(rst_b),
	.run_mode(run_mode), .command_word_lines(command_word_lines), .error_event(error_event),
	.result_load(result_load), .result_data_in(result_data_in), .action(action),
	.active_bank(active_bank), .active_group(active_group), .rereg_item(rereg_item),
	.error_out(error_out), .overall_result_out(overall_result_out),
	.result_data_out(result_data_out));
